// ### logic/lfsa_pkg.sv
// lfsa_pkg: constants shared by the lock/fuse self-access device and its cpu-side end
// assumes a single 100 MHz clock on both ends
package lfsa_pkg;
	// ----------------------------------------
	// control/status register layout
	// ----------------------------------------
	localparam int unsigned CTRL_ENABLE_POS = 0;
	localparam int unsigned CTRL_LOCK_SEL_POS = 3;
	localparam logic [7:0] CTRL_LOCK_WRITE = 8'h09;
	localparam logic [7:0] CTRL_LOCK_WRITE_MASK = 8'h7f;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ----------------------------------------
	// z-pointer selections
	// ----------------------------------------
	localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
	localparam logic [15:0] Z_LOCK = 16'h0001;
	localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
	localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned STORE_WINDOW = 4;
	localparam int unsigned LOAD_WINDOW = 3;
	localparam int unsigned PROG_MIN_US = 3700;
	localparam int unsigned PROG_MAX_US = 4500;
	localparam int unsigned PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
	// ----------------------------------------
	// apb map of the cpu-side end
	// ----------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_ZPTR = 8'h04;
	localparam logic [7:0] A_WORK = 8'h08;
	localparam logic [7:0] A_RESULT = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_IRQ_STAT = 8'h14;
	localparam logic [7:0] A_IRQ_MASK = 8'h18;
	localparam logic [7:0] A_CTRL_RD = 8'h1c;
	// command codes written to A_CMD
	localparam logic [1:0] CMD_SET_CTRL = 2'h1;
	localparam logic [1:0] CMD_STORE = 2'h2;
	localparam logic [1:0] CMD_LOAD = 2'h3;
	// interrupt status bits
	localparam int unsigned IRQ_DONE_POS = 0;
	localparam int unsigned IRQ_REFUSED_POS = 1;
	localparam int unsigned IRQ_IDLE_POS = 2;
endpackage : lfsa_pkg

// ### logic/lfsa_if.sv
// lfsa_if: cpu-to-device link for control writes, store and load instructions
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface lfsa_if;
	logic ctrl_wr;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl_rdata;
	logic store;
	logic load;
	logic [15:0] zptr;
	logic [7:0] work;
	logic [7:0] load_data;
	logic load_special;
	logic load_refused;
	logic load_valid;
	modport dev (input ctrl_wr, input ctrl_wdata, output ctrl_rdata, input store, input load, input zptr,
		input work, output load_data, output load_special, output load_refused, output load_valid);
	modport cpu (output ctrl_wr, output ctrl_wdata, input ctrl_rdata, output store, output load, output zptr,
		output work, input load_data, input load_special, input load_refused, input load_valid);
endinterface : lfsa_if

// ### logic/lfsa_device.sv
// lfsa_device: lock-bit programming and fuse/lock readback behind the cpu's control register
// assumes the cpu end keeps its timing windows and that eeprom busy comes from the same clock
`timescale 1ns/1ns
module lfsa_device #(
	parameter int unsigned PROG_CYCLES = lfsa_pkg::PROG_CYCLES,
	parameter logic [7:0] FUSE_LOW = 8'hff,
	parameter logic [7:0] FUSE_HIGH = 8'hff,
	parameter logic [2:0] FUSE_EXT = 3'h7
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// cpu link
	lfsa_if.dev link,
	// eeprom controller and flash status
	input wire logic eeprom_write_strobe_in,
	input wire logic spm_irq_enable_in,
	output logic flash_readable_out,
	output logic prog_busy_out,
	output logic spm_irq_out,
	output logic [5:0] lock_bits_out
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {LFSA_IDLE, LFSA_ARMED, LFSA_PROG} lfsa_state_t;
	lfsa_state_t state;
	lfsa_state_t next_state;
	logic [7:0] selfprog_ctrl_status;
	logic [7:0] next_ctrl;
	logic [2:0] age;
	logic [2:0] next_age;
	logic [31:0] prog_count;
	// nonvolatile cells: the power-up value stands for erased cells, and reset leaves them alone
	logic [5:0] lock_store = 6'h3f;
	logic [5:0] lock_pending;
	logic [7:0] next_load_data;
	logic next_refused;

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	wire lock_select_bit = selfprog_ctrl_status[lfsa_pkg::CTRL_LOCK_SEL_POS];
	wire selfprog_enable_bit = selfprog_ctrl_status[lfsa_pkg::CTRL_ENABLE_POS];
	wire read_armed = lock_select_bit && selfprog_enable_bit && state == LFSA_ARMED;
	wire is_lock_write = (selfprog_ctrl_status & lfsa_pkg::CTRL_LOCK_WRITE_MASK) == lfsa_pkg::CTRL_LOCK_WRITE;
	// a store may follow the control write by four cycles, a load only by three
	wire store_ok = state == LFSA_ARMED && is_lock_write && age < 3'(lfsa_pkg::STORE_WINDOW);
	wire load_in_window = read_armed && age < 3'(lfsa_pkg::LOAD_WINDOW);
	wire load_hit = link.load && load_in_window && !eeprom_write_strobe_in;
	wire start_prog = link.store && store_ok && !eeprom_write_strobe_in;
	wire window_over = age >= 3'(lfsa_pkg::STORE_WINDOW - 1) && !link.store && !link.load;
	wire prog_done = state == LFSA_PROG && prog_count == PROG_CYCLES - 1;
	// a control write outranks an instruction in the same cycle
	wire take_store = rst_n_in && start_prog && !link.ctrl_wr;
	wire close_window = !start_prog && (load_hit || (state == LFSA_ARMED && window_over));
	// age saturates so that a long run of loads or stores past the window cannot wrap it back into the window
	wire age_runs = state == LFSA_ARMED && !close_window && age != 3'h7;

	// ----------------------------------------
	// readback select
	// ----------------------------------------
	function automatic logic [7:0] lfsa_sel(input logic [15:0] z, input logic [5:0] lk);
		unique case (z)
			lfsa_pkg::Z_FUSE_LOW: lfsa_sel = FUSE_LOW;
			lfsa_pkg::Z_LOCK: lfsa_sel = {2'h3, lk};
			lfsa_pkg::Z_FUSE_EXT: lfsa_sel = {5'h1f, FUSE_EXT};
			lfsa_pkg::Z_FUSE_HIGH: lfsa_sel = FUSE_HIGH;
			default: lfsa_sel = 8'hff;
		endcase
	endfunction : lfsa_sel

	// ----------------------------------------
	// next values
	// ----------------------------------------
	assign next_state = link.ctrl_wr ? LFSA_ARMED : start_prog ? LFSA_PROG : close_window ? LFSA_IDLE : state;
	assign next_ctrl = link.ctrl_wr ? link.ctrl_wdata : close_window ? lfsa_pkg::CTRL_RESET : selfprog_ctrl_status;
	assign next_age = link.ctrl_wr ? 3'h0 : age_runs ? age + 3'h1 : age;
	assign next_refused = link.load && load_in_window && eeprom_write_strobe_in;
	assign next_load_data = load_hit ? lfsa_sel(link.zptr, lock_store) : 8'hff;

	// ----------------------------------------
	// control sequence
	// ----------------------------------------
	// a write in flight is tested before reset, so reset cannot cut it short
	always_ff @(posedge clock_in)
	begin
		if (state == LFSA_PROG)
		begin
			if (prog_done)
				state <= LFSA_IDLE;
		end
		else if (!rst_n_in)
			state <= LFSA_IDLE;
		else
			state <= next_state;
	end

	// the enable bit stays up through programming so software can poll for the end
	always_ff @(posedge clock_in)
	begin
		if (state == LFSA_PROG)
		begin
			if (prog_done)
				selfprog_ctrl_status <= lfsa_pkg::CTRL_RESET;
		end
		else if (!rst_n_in)
			selfprog_ctrl_status <= lfsa_pkg::CTRL_RESET;
		else
			selfprog_ctrl_status <= next_ctrl;
	end

	// ----------------------------------------
	// window timing
	// ----------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
			age <= 3'h0;
		else
			age <= next_age;
	end

	// ----------------------------------------
	// programming timer
	// ----------------------------------------
	// the timer ignores reset so a started write completes
	always_ff @(posedge clock_in)
	begin
		if (state == LFSA_PROG && !prog_done)
			prog_count <= prog_count + 32'h1;
		else
			prog_count <= 32'h0;
	end

	// ----------------------------------------
	// lock cells
	// ----------------------------------------
	// zero work bits pick the cells to program; the z-pointer plays no part
	always_ff @(posedge clock_in)
	begin
		if (take_store)
			lock_pending <= ~link.work[5:0];
	end

	// cells only ever move towards programmed; erase is out of reach from here
	always_ff @(posedge clock_in)
	begin
		if (prog_done)
			lock_store <= lock_store & ~lock_pending;
	end

	// ----------------------------------------
	// load answers
	// ----------------------------------------
	// every load is answered one cycle later, whatever the mode
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			link.load_data <= 8'h00;
			link.load_valid <= 1'b0;
			link.load_special <= 1'b0;
			link.load_refused <= 1'b0;
		end
		else
		begin
			link.load_valid <= link.load;
			link.load_special <= load_hit;
			link.load_refused <= next_refused;
			link.load_data <= next_load_data;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	// lock programming touches no array the core fetches from, so fetch never stalls
	assign link.ctrl_rdata = selfprog_ctrl_status;
	assign flash_readable_out = 1'b1;
	assign prog_busy_out = state == LFSA_PROG;
	assign spm_irq_out = spm_irq_enable_in && !selfprog_enable_bit;
	assign lock_bits_out = lock_store;
endmodule : lfsa_device

// ### logic/lfsa_cpu.sv
// lfsa_cpu: cpu-side end driven by software over apb; passes store and load commands on as software writes them, control writes only while eeprom is not busy
// assumes an apb master on the same clock
`timescale 1ns/1ns
module lfsa_cpu (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// eeprom status seen by software
	input wire logic eeprom_write_strobe_in,
	output logic irq_out,
	// device link
	lfsa_if.cpu link
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] zptr;
	logic [7:0] work;
	logic [7:0] result;
	logic result_special;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [7:0] eeprom_ctrl;

	wire wr = psel && penable && pwrite;
	wire wr_cmd = wr && paddr == lfsa_pkg::A_CMD;
	wire [1:0] cmd = pwdata[9:8];
	wire cmd_refused = wr_cmd && cmd == lfsa_pkg::CMD_SET_CTRL && eeprom_write_strobe_in;
	wire mapped = paddr <= lfsa_pkg::A_CTRL_RD && paddr[1:0] == 2'h0;
	wire [2:0] ev = {!link.ctrl_rdata[lfsa_pkg::CTRL_ENABLE_POS], link.load_refused, link.load_valid};

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign eeprom_ctrl = {7'h00, eeprom_write_strobe_in};
	// one apb write every two cycles, so store/load fall within the window when software issues them promptly
	assign link.ctrl_wr = wr_cmd && cmd == lfsa_pkg::CMD_SET_CTRL && !cmd_refused;
	assign link.ctrl_wdata = pwdata[7:0];
	assign link.store = wr_cmd && cmd == lfsa_pkg::CMD_STORE;
	assign link.load = wr_cmd && cmd == lfsa_pkg::CMD_LOAD;
	assign link.zptr = zptr;
	assign link.work = work;
	assign irq_out = |(irq_stat & irq_mask);

	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			zptr <= lfsa_pkg::Z_LOCK;
			work <= 8'hff;
			result <= 8'h00;
			result_special <= 1'b0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
		end
		else
		begin
			if (wr && paddr == lfsa_pkg::A_ZPTR)
				zptr <= pwdata[15:0];
			if (wr && paddr == lfsa_pkg::A_WORK)
				work <= pwdata[7:0];
			if (wr && paddr == lfsa_pkg::A_IRQ_MASK)
				irq_mask <= pwdata[2:0];
			if (link.load_valid)
			begin
				result <= link.load_data;
				result_special <= link.load_special;
			end
			// set wins over write-one-to-clear
			irq_stat <= (irq_stat & ~((wr && paddr == lfsa_pkg::A_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
		end
	end

	always_comb
	begin
		unique case (paddr)
			lfsa_pkg::A_ZPTR: prdata = {16'h0000, zptr};
			lfsa_pkg::A_WORK: prdata = {24'h000000, work};
			lfsa_pkg::A_RESULT: prdata = {23'h000000, result_special, result};
			lfsa_pkg::A_STATUS: prdata = {24'h000000, eeprom_ctrl};
			lfsa_pkg::A_IRQ_STAT: prdata = {29'h00000000, irq_stat};
			lfsa_pkg::A_IRQ_MASK: prdata = {29'h00000000, irq_mask};
			lfsa_pkg::A_CTRL_RD: prdata = {24'h000000, link.ctrl_rdata};
			default: prdata = 32'h00000000;
		endcase
	end
endmodule : lfsa_cpu

// ### dv/lfsa_link_sva.sv
// lfsa_link_sva: assertions on the link between cpu end and device
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module lfsa_link_sva (
	// link and device status
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_rdata,
	input wire logic store,
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic load_special,
	input wire logic load_refused,
	input wire logic load_valid,
	input wire logic eeprom_write_strobe_in,
	input wire logic prog_busy_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	wire logic armed = ctrl_rdata[0] && ctrl_rdata[3];
	sequence s_special;
		load && armed && !eeprom_write_strobe_in && !prog_busy_out;
	endsequence
	// a rewrite of the control byte restarts the window, so it ends the quiet run too
	sequence s_quiet;
		ctrl_wr ##1 (!store && !load && !ctrl_wr)[*4];
	endsequence
	a_load_answered: assert property (load |=> load_valid || load_refused)
		else $error("load got no answer");
	a_answer_cause: assert property (load_valid |-> $past(load))
		else $error("answer without load");
	a_plain_load: assert property (load && !armed |=> load_valid && !load_special && load_data == 8'hff)
		else $error("plain load wrong");
	a_special_load: assert property (s_special |=> load_valid && load_special)
		else $error("special load not special");
	a_read_refused: assert property (load && armed && eeprom_write_strobe_in && !prog_busy_out
		|=> load_refused && !load_special)
		else $error("read not refused");
	a_read_clears: assert property (s_special |-> ##[1:2] !armed)
		else $error("bits kept after read");
	a_idle_clears: assert property (s_quiet |=> !armed)
		else $error("bits kept after window");
	a_prog_holds: assert property (store && ctrl_rdata[6:0] == 7'h09 && !eeprom_write_strobe_in && !prog_busy_out
		|=> (ctrl_rdata[0] && prog_busy_out)[*8])
		else $error("enable dropped early");
	a_busy_blocks: assert property (store && eeprom_write_strobe_in && !prog_busy_out |=> !prog_busy_out)
		else $error("write not blocked");
endmodule : lfsa_link_sva

// ### dv/tb_top.sv
// tb_top: apb software drives the cpu end, which faces the device over the link
// assumes zero-wait apb and a programming count cut to PROG cycles
`timescale 1ns/1ns
module tb_top;
	// ----------------------------------------
	// bench
	// ----------------------------------------
	localparam int unsigned PROG = 20;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic eeprom = 1'b0;
	logic irq_en = 1'b1;
	logic flash_readable;
	logic prog_busy;
	logic spm_irq;
	logic irq;
	logic [5:0] lock_bits;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	logic [15:0] zs [4] = '{16'h0000, 16'h0003, 16'h0002, 16'h0001};
	logic [7:0] es [4] = '{8'ha5, 8'h3c, 8'h05, 8'hff};
	lfsa_if lfsa_if_i ();
	lfsa_device #(.PROG_CYCLES(PROG), .FUSE_LOW(8'ha5), .FUSE_HIGH(8'h3c), .FUSE_EXT(3'h5)) lfsa_device_i (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .link(lfsa_if_i), .eeprom_write_strobe_in(eeprom),
		.spm_irq_enable_in(irq_en), .flash_readable_out(flash_readable), .prog_busy_out(prog_busy),
		.spm_irq_out(spm_irq), .lock_bits_out(lock_bits));
	lfsa_cpu lfsa_cpu_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eeprom_write_strobe_in(eeprom), .irq_out(irq), .link(lfsa_if_i));
	lfsa_link_sva lfsa_link_sva_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .ctrl_wr(lfsa_if_i.ctrl_wr),
		.ctrl_rdata(lfsa_if_i.ctrl_rdata), .store(lfsa_if_i.store), .load(lfsa_if_i.load),
		.load_data(lfsa_if_i.load_data), .load_special(lfsa_if_i.load_special), .load_refused(lfsa_if_i.load_refused),
		.load_valid(lfsa_if_i.load_valid), .eeprom_write_strobe_in(eeprom), .prog_busy_out(prog_busy));
	initial
	begin
		forever #5 clock_in = ~clock_in;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	// under two hundred cycles are expected, so a hang shows well before the ceiling
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		@(posedge clock_in);
		while (pready !== 1'b1)
			@(posedge clock_in);
		rd = prdata;
		err = pslverr;
	endtask : apb
	task automatic idle(input int k);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (k) @(posedge clock_in);
	endtask : idle
	task automatic op(input logic [15:0] z, input logic [7:0] w, input logic [7:0] c, input logic [1:0] cmd);
		apb(1'b1, lfsa_pkg::A_ZPTR, {16'h0, z});
		apb(1'b1, lfsa_pkg::A_WORK, {24'h0, w});
		apb(1'b1, lfsa_pkg::A_CMD, {22'h0, lfsa_pkg::CMD_SET_CTRL, c});
		apb(1'b1, lfsa_pkg::A_CMD, {22'h0, cmd, 8'h00});
		idle(1);
	endtask : op
	// eeprom goes busy after the control write has left, in the same cycle the instruction reaches the link
	task automatic ee_op(input logic [1:0] cmd);
		apb(1'b1, lfsa_pkg::A_CMD, {22'h0, lfsa_pkg::CMD_SET_CTRL, 8'h09});
		fork
			apb(1'b1, lfsa_pkg::A_CMD, {22'h0, cmd, 8'h00});
			begin
				@(posedge clock_in);
				eeprom <= 1'b1;
			end
		join
		idle(3);
	endtask : ee_op
	task automatic wait_prog;
		n = 0;
		while (prog_busy === 1'b1 && n < 1000)
		begin
			@(posedge clock_in);
			n++;
		end
		idle(1);
	endtask : wait_prog
	initial
	begin
		repeat (4) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		apb(1'b0, lfsa_pkg::A_WORK, 32'h0);
		chk("work reset", 32'hff, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 1, err);
		for (int i = 0; i < 4; i++)
		begin
			op(zs[i], 8'hff, 8'h09, lfsa_pkg::CMD_LOAD);
			apb(1'b0, lfsa_pkg::A_RESULT, 32'h0);
			chk("special read", {24'h1, es[i]}, rd & (i == 2 ? 32'h107 : 32'h1ff));
			apb(1'b0, lfsa_pkg::A_CTRL_RD, 32'h0);
			chk("ctrl after read", 0, rd & 32'h9);
		end
		apb(1'b1, lfsa_pkg::A_IRQ_MASK, 32'h0);
		idle(1);
		chk("irq masked", 0, irq);
		apb(1'b1, lfsa_pkg::A_IRQ_MASK, 32'h1);
		idle(1);
		chk("irq raised", 1, irq);
		apb(1'b1, lfsa_pkg::A_IRQ_STAT, 32'h7);
		idle(1);
		chk("irq cleared", 0, irq);
		$display("test reads and irq done");
		apb(1'b1, lfsa_pkg::A_CMD, {22'h0, lfsa_pkg::CMD_SET_CTRL, 8'h09});
		idle(8);
		apb(1'b0, lfsa_pkg::A_CTRL_RD, 32'h0);
		chk("ctrl after window", 0, rd & 32'h9);
		op(16'h0000, 8'hff, 8'h00, lfsa_pkg::CMD_LOAD);
		apb(1'b0, lfsa_pkg::A_RESULT, 32'h0);
		chk("plain load", 32'hff, rd & 32'h1ff);
		$display("test window done");
		op(16'h1234, 8'hea, 8'h09, lfsa_pkg::CMD_STORE);
		chk("locks mid write", 6'h3f, lock_bits);
		chk("flash readable", 1, flash_readable);
		chk("spm irq busy", 0, spm_irq);
		apb(1'b0, lfsa_pkg::A_CTRL_RD, 32'h0);
		chk("enable held", 1, rd[0]);
		wait_prog();
		chk("prog time", 1, n + 4 >= PROG && n <= PROG * 45 / 37);
		chk("locks written", 6'h2a, lock_bits);
		chk("spm irq idle", 1, spm_irq);
		$display("test lock write done");
		apb(1'b0, lfsa_pkg::A_WORK, 32'h0);
		ee_op(lfsa_pkg::CMD_LOAD);
		apb(1'b0, lfsa_pkg::A_STATUS, 32'h0);
		chk("eeprom status", 1, rd[0]);
		apb(1'b0, lfsa_pkg::A_IRQ_STAT, 32'h0);
		chk("read refused", 1, rd[1]);
		idle(1);
		eeprom <= 1'b0;
		apb(1'b1, lfsa_pkg::A_WORK, 32'h0);
		ee_op(lfsa_pkg::CMD_STORE);
		chk("store blocked", {1'b0, 6'h2a}, {prog_busy, lock_bits});
		eeprom <= 1'b0;
		$display("test eeprom done");
		op(16'h0001, 8'hdf, 8'h09, lfsa_pkg::CMD_STORE);
		idle(2);
		rst_n_in <= 1'b0;
		idle(2);
		rst_n_in <= 1'b1;
		wait_prog();
		chk("busy over reset", 1, n > 0);
		chk("locks after reset", 6'h0a, lock_bits);
		$display("test reset done");
		give_verdict();
	end
endmodule : tb_top
